/* File: shared/eeprom_seq_pkg.sv */
// constants and carrier types for the eeprom command sequencer
package eeprom_seq_pkg;

  // register byte offsets on the apb bus
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OP_CONTROL_OFF = 12'h1B4;
  localparam logic [ADDR_W-1:0] BYTE_BUFFER_OFF = 12'h1B8;
  localparam logic [ADDR_W-1:0] HW_CONFIG_OFF = 12'h1BC;

  // field positions in eeprom_op_control
  localparam int unsigned BUSY_BIT = 31;
  localparam int unsigned OP_LSB = 28;
  localparam int unsigned TIMEOUT_BIT = 17;
  localparam int unsigned LOADED_BIT = 16;
  localparam int unsigned POINTER_LSB = 0;
  // field position in hardware_config_reg
  localparam int unsigned READY_BIT = 0;

  // operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_RELOAD = 3'h7;

  // values after reset
  localparam logic [2:0] OP_RESET = 3'h0;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [7:0] BUFFER_RESET = 8'h00;
  localparam logic READY_RESET = 1'b1;

  // marker byte that a programmed eeprom holds at location zero
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [15:0] SIGNATURE_ADDR = 16'h0000;

  // eeprom access response timeout (read, write and reload)
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TIMEOUT_MS = 30;
  localparam int unsigned TIMEOUT_CYCLES = (TIMEOUT_MS * CLK_HZ) / 1000;

  // request to the eeprom access engine, held until ack or timeout
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ee_req_t;

  // answer from the eeprom access engine, ack is one cycle
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } ee_rsp_t;

endpackage

/* File: hw/eeprom_command_sequencer.sv */
// eeprom command sequencer: apb registers, read/write/reload sequencing, timeout
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module eeprom_command_sequencer #(
  parameter int unsigned TIMEOUT_CYCLES = eeprom_seq_pkg::TIMEOUT_CYCLES,
  parameter int unsigned CNT_W = 20
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [eeprom_seq_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // eeprom access engine
  output var eeprom_seq_pkg::ee_req_t ee_req_out,
  input wire eeprom_seq_pkg::ee_rsp_t ee_rsp_in,
  input wire logic ee_write_enabled_in,
  // configuration loader
  output logic loader_start_out,
  input wire logic loader_done_in,
  // device status
  output logic device_ready_out
);

  typedef enum logic [1:0] {
    st_idle,
    st_access,
    st_load
  } state_t;

  state_t state_q, state_d;
  logic [2:0] op_q, op_d;
  logic [15:0] pointer_q, pointer_d;
  logic [7:0] buffer_q, buffer_d;
  logic busy_q, busy_d;
  logic timeout_q, timeout_d;
  logic loaded_q, loaded_d;
  logic ready_q, ready_d;
  logic load_start_q, load_start_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [31:0] prdata_q, prdata_d;
  eeprom_seq_pkg::ee_req_t ee_q, ee_d;

  logic bus_wr;
  logic bus_setup_rd;
  logic hit_ctrl;
  logic hit_buf;
  logic hit_cfg;
  logic last_cycle;

  function automatic eeprom_seq_pkg::ee_req_t make_req(input logic wr, input logic [15:0] addr,
                                                       input logic [7:0] wdata);
    eeprom_seq_pkg::ee_req_t r;
    r.req = 1'b1;
    r.write = wr;
    r.addr = addr;
    r.wdata = wdata;
    return r;
  endfunction

  assign hit_ctrl = (paddr_in == eeprom_seq_pkg::OP_CONTROL_OFF);
  assign hit_buf = (paddr_in == eeprom_seq_pkg::BYTE_BUFFER_OFF);
  assign hit_cfg = (paddr_in == eeprom_seq_pkg::HW_CONFIG_OFF);
  assign bus_wr = psel_in & penable_in & pwrite_in;
  assign bus_setup_rd = psel_in & ~penable_in & ~pwrite_in;
  assign last_cycle = (cnt_q == CNT_W'(TIMEOUT_CYCLES - 1));

  // zero wait state slave; read data is captured in the setup cycle
  assign pready_out = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~(hit_ctrl | hit_buf | hit_cfg);
  assign prdata_out = prdata_q;
  assign ee_req_out = ee_q;
  assign loader_start_out = load_start_q;
  assign device_ready_out = ready_q;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    pointer_d = pointer_q;
    buffer_d = buffer_q;
    busy_d = busy_q;
    timeout_d = timeout_q;
    loaded_d = loaded_q;
    ready_d = ready_q;
    load_start_d = 1'b0;
    cnt_d = cnt_q;
    prdata_d = prdata_q;
    ee_d = ee_q;

    // read mux
    if (bus_setup_rd) begin
      prdata_d = 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_d[eeprom_seq_pkg::BUSY_BIT] = busy_q;
        prdata_d[eeprom_seq_pkg::OP_LSB +: 3] = op_q;
        prdata_d[eeprom_seq_pkg::TIMEOUT_BIT] = timeout_q;
        prdata_d[eeprom_seq_pkg::LOADED_BIT] = loaded_q;
        prdata_d[eeprom_seq_pkg::POINTER_LSB +: 16] = pointer_q;
      end else if (hit_buf) begin
        prdata_d[7:0] = buffer_q;
      end else if (hit_cfg) begin
        prdata_d[eeprom_seq_pkg::READY_BIT] = ready_q;
      end
    end

    // software writes; flags are write-one-to-clear and lose to a hardware set below
    if (bus_wr && hit_ctrl) begin
      if (pwdata_in[eeprom_seq_pkg::TIMEOUT_BIT]) begin
        timeout_d = 1'b0;
      end
      if (pwdata_in[eeprom_seq_pkg::LOADED_BIT]) begin
        loaded_d = 1'b0;
      end
      // code and pointer are frozen while a command runs
      if (!busy_q) begin
        op_d = pwdata_in[eeprom_seq_pkg::OP_LSB +: 3];
        pointer_d = pwdata_in[eeprom_seq_pkg::POINTER_LSB +: 16];
        busy_d = pwdata_in[eeprom_seq_pkg::BUSY_BIT];
      end
    end
    if (bus_wr && hit_buf && !busy_q) begin
      buffer_d = pwdata_in[7:0];
    end

    unique case (state_q)
      st_idle: begin
        cnt_d = '0;
        if (busy_q) begin
          case (op_q)
            eeprom_seq_pkg::OP_READ: begin
              ee_d = make_req(1'b0, pointer_q, buffer_q);
              state_d = st_access;
            end
            eeprom_seq_pkg::OP_WRITE: begin
              if (ee_write_enabled_in) begin
                ee_d = make_req(1'b1, pointer_q, buffer_q);
                state_d = st_access;
              end else begin
                // protected eeprom: nothing is written, the command just ends
                busy_d = 1'b0;
              end
            end
            eeprom_seq_pkg::OP_RELOAD: begin
              loaded_d = 1'b0;
              ready_d = 1'b0;
              ee_d = make_req(1'b0, eeprom_seq_pkg::SIGNATURE_ADDR, buffer_q);
              state_d = st_access;
            end
            default: begin
              timeout_d = 1'b1;
              busy_d = 1'b0;
            end
          endcase
        end
      end
      st_access: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (ee_rsp_in.ack) begin
          ee_d.req = 1'b0;
          cnt_d = '0;
          if (op_q == eeprom_seq_pkg::OP_RELOAD) begin
            if (ee_rsp_in.rdata == eeprom_seq_pkg::SIGNATURE) begin
              load_start_d = 1'b1;
              state_d = st_load;
            end else begin
              // blank eeprom: reload fails, device becomes usable again
              ready_d = 1'b1;
              busy_d = 1'b0;
              state_d = st_idle;
            end
          end else begin
            if (op_q == eeprom_seq_pkg::OP_READ) begin
              buffer_d = ee_rsp_in.rdata;
            end
            busy_d = 1'b0;
            state_d = st_idle;
          end
        end else if (last_cycle) begin
          // a hung eeprom must not lock the host out forever
          ee_d.req = 1'b0;
          timeout_d = 1'b1;
          busy_d = 1'b0;
          if (op_q == eeprom_seq_pkg::OP_RELOAD) begin
            ready_d = 1'b1;
          end
          state_d = st_idle;
        end
      end
      st_load: begin
        if (loader_done_in) begin
          loaded_d = 1'b1;
          ready_d = 1'b1;
          busy_d = 1'b0;
          state_d = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= st_idle;
      op_q <= eeprom_seq_pkg::OP_RESET;
      pointer_q <= eeprom_seq_pkg::POINTER_RESET;
      buffer_q <= eeprom_seq_pkg::BUFFER_RESET;
      busy_q <= 1'b0;
      timeout_q <= 1'b0;
      loaded_q <= 1'b0;
      ready_q <= eeprom_seq_pkg::READY_RESET;
      load_start_q <= 1'b0;
      cnt_q <= '0;
      prdata_q <= 32'h0000_0000;
      ee_q <= '0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      pointer_q <= pointer_d;
      buffer_q <= buffer_d;
      busy_q <= busy_d;
      timeout_q <= timeout_d;
      loaded_q <= loaded_d;
      ready_q <= ready_d;
      load_start_q <= load_start_d;
      cnt_q <= cnt_d;
      prdata_q <= prdata_d;
      ee_q <= ee_d;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence read_ack_s;
    state_q == st_access && op_q == eeprom_seq_pkg::OP_READ && ee_rsp_in.ack;
  endsequence

  sequence sig_ok_s;
    state_q == st_access && op_q == eeprom_seq_pkg::OP_RELOAD && ee_rsp_in.ack &&
      ee_rsp_in.rdata == eeprom_seq_pkg::SIGNATURE;
  endsequence

  sequence sig_bad_s;
    state_q == st_access && op_q == eeprom_seq_pkg::OP_RELOAD && ee_rsp_in.ack &&
      ee_rsp_in.rdata != eeprom_seq_pkg::SIGNATURE;
  endsequence

  read_address_a: assert property (
    state_q == st_access && op_q == eeprom_seq_pkg::OP_READ |-> ee_q.req && !ee_q.write && ee_q.addr == pointer_q)
    else $error("read request does not carry the pointer");

  read_result_a: assert property (
    read_ack_s |=> buffer_q == $past(ee_rsp_in.rdata) && !busy_q && state_q == st_idle)
    else $error("read byte not placed in buffer");

  write_gate_a: assert property (
    $rose(ee_q.req) && ee_q.write |-> $past(ee_write_enabled_in) && ee_q.wdata == buffer_q && ee_q.addr == pointer_q)
    else $error("write issued while protected or with wrong data");

  reload_start_a: assert property (
    sig_ok_s |=> load_start_q ##1 (!load_start_q && state_q == st_load))
    else $error("loader not started after valid signature");

  blank_fail_a: assert property (
    sig_bad_s |=> !load_start_q && !loaded_q && ready_q && state_q == st_idle)
    else $error("blank eeprom did not fail the reload");

  loaded_set_a: assert property (
    $rose(loaded_q) |-> $past(state_q) == st_load && $past(loader_done_in))
    else $error("loaded flag set without a finished reload");

  not_ready_a: assert property (
    state_q != st_idle && op_q == eeprom_seq_pkg::OP_RELOAD |-> !ready_q)
    else $error("device ready during reload");

  dispatch_a: assert property (
    state_q == st_idle && busy_q && op_q == eeprom_seq_pkg::OP_READ |=> state_q == st_access && ee_q.req)
    else $error("read command not dispatched");

  bad_code_a: assert property (
    state_q == st_idle && busy_q && op_q != eeprom_seq_pkg::OP_READ && op_q != eeprom_seq_pkg::OP_WRITE &&
      op_q != eeprom_seq_pkg::OP_RELOAD |=> timeout_q && !busy_q)
    else $error("unsupported code did not time out");

  timeout_end_a: assert property (
    state_q == st_access && last_cycle && !ee_rsp_in.ack |=> timeout_q && !busy_q && !ee_q.req)
    else $error("timeout did not end the access");

  busy_end_a: assert property (
    $fell(busy_q) |-> state_q == st_idle && !ee_q.req)
    else $error("busy cleared while command still running");

endmodule

`default_nettype wire

/* File: testbench/eeprom_partner_model.sv */
// behavioural eeprom access engine and configuration loader facing the sequencer
`timescale 1ns/1ps
`default_nettype none

module eeprom_partner_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // access engine side
  input wire eeprom_seq_pkg::ee_req_t req_in,
  output var eeprom_seq_pkg::ee_rsp_t rsp_out,
  input wire logic [3:0] delay_in,
  input wire logic mute_in,
  // loader side
  input wire logic start_in,
  output logic done_out
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_q;
  logic served_q;
  logic [7:0] last_q;
  logic [2:0] load_q;

  // a blank part reads all ones
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 4'h0;
      served_q <= 1'b0;
      rsp_out <= '0;
      last_q <= 8'h00;
      load_q <= 3'h0;
      done_out <= 1'b0;
    end else begin
      rsp_out.ack <= 1'b0;
      // data outside an answer is the inverse of the last byte, never a stale copy
      rsp_out.rdata <= ~last_q;
      done_out <= (load_q == 3'h1);
      if (start_in) load_q <= 3'h4;
      else if (load_q != 3'h0) load_q <= load_q - 3'h1;
      if (!req_in.req) begin
        wait_q <= 4'h0;
        served_q <= 1'b0;
      end else if (!served_q && !mute_in) begin
        if (wait_q == delay_in) begin
          served_q <= 1'b1;
          rsp_out.ack <= 1'b1;
          rsp_out.rdata <= mem[req_in.addr];
          last_q <= mem[req_in.addr];
          if (req_in.write) mem[req_in.addr] <= req_in.wdata;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the eeprom command sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [11:0] CTRL = eeprom_seq_pkg::OP_CONTROL_OFF;
  localparam logic [11:0] BUF = eeprom_seq_pkg::BYTE_BUFFER_OFF;
  localparam logic [11:0] HWC = eeprom_seq_pkg::HW_CONFIG_OFF;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic we = 1'b0, mute = 1'b0, err, pready, pslverr, ld_start, ld_done, ready;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] delay = 4'h1;
  eeprom_seq_pkg::ee_req_t ee_req;
  eeprom_seq_pkg::ee_rsp_t ee_rsp;
  int failures = 0, num_checks = 0, starts = 0;

  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (ld_start === 1'b1) starts <= starts + 1;

  // short timeout keeps the timeout case fast
  eeprom_command_sequencer #(.TIMEOUT_CYCLES(16), .CNT_W(20)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ee_req_out(ee_req), .ee_rsp_in(ee_rsp),
    .ee_write_enabled_in(we), .loader_start_out(ld_start), .loader_done_in(ld_done), .device_ready_out(ready));
  eeprom_partner_model u_model (.clk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(ee_req), .rsp_out(ee_rsp),
    .delay_in(delay), .mute_in(mute), .start_in(ld_start), .done_out(ld_done));

  // waits for pready however long it takes; only the watchdog ends a hung transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  function automatic logic [31:0] op(input logic [2:0] c, input logic [15:0] p);
    return {1'b1, c, 12'h000, p};
  endfunction

  // polls up to 100 times until the command finishes; rd then holds the control word
  task automatic run(input logic [31:0] w);
    apb(1'b1, CTRL, w);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, CTRL, 32'h0);
      if (rd[31] === 1'b0) break;
    end
    check("busy_done", 32'h0, {31'h0, rd[31]});
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    check("op_control", 32'h0, rd);
    apb(1'b0, BUF, 32'h0);
    check("byte_buffer", 32'h0, rd);
    apb(1'b0, HWC, 32'h0);
    check("hw_config", 32'h1, rd);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, BUF, 32'h5A);
    run(op(eeprom_seq_pkg::OP_WRITE, 16'h0124));
    check("mem_124", 32'hFF, {24'h0, u_model.mem[16'h0124]});
    we <= 1'b1;
    run(op(eeprom_seq_pkg::OP_WRITE, 16'h0123));
    check("mem_123", 32'h5A, {24'h0, u_model.mem[16'h0123]});
    check("busy_write", 32'h0, {31'h0, rd[31]});
    $display("test write done");
    apb(1'b1, BUF, 32'h0);
    delay <= 4'h8;
    run(op(eeprom_seq_pkg::OP_READ, 16'h0123));
    apb(1'b0, BUF, 32'h0);
    check("read_data", 32'h5A, rd);
    $display("test read done");
    apb(1'b1, CTRL, op(eeprom_seq_pkg::OP_RELOAD, 16'h0000));
    repeat (3) @(posedge mclk_in);
    apb(1'b0, HWC, 32'h0);
    check("ready_low", 32'h0, rd);
    check("ready_pin_low", 32'h0, {31'h0, ready});
    run(32'h0);
    check("loaded_blank", 32'h0, {31'h0, rd[16]});
    check("starts_blank", 32'h0, 32'(starts));
    apb(1'b0, HWC, 32'h0);
    check("ready_back", 32'h1, rd);
    $display("test blank reload done");
    delay <= 4'h1;
    apb(1'b1, BUF, 32'hA5);
    run(op(eeprom_seq_pkg::OP_WRITE, 16'h0000));
    run(op(eeprom_seq_pkg::OP_RELOAD, 16'h0000));
    check("loaded_ok", 32'h1, {31'h0, rd[16]});
    check("starts_ok", 32'h1, 32'(starts));
    apb(1'b0, HWC, 32'h0);
    check("ready_ok", 32'h1, rd);
    check("ready_pin_ok", 32'h1, {31'h0, ready});
    $display("test reload done");
    mute <= 1'b1;
    run(op(eeprom_seq_pkg::OP_READ, 16'h0005));
    check("timeout_set", 32'h1, {31'h0, rd[17]});
    check("busy_timeout", 32'h0, {31'h0, rd[31]});
    apb(1'b1, CTRL, 32'h0002_0000);
    apb(1'b0, CTRL, 32'h0);
    check("timeout_clear", 32'h0, {31'h0, rd[17]});
    // a write that the eeprom never answers must give up as well
    run(op(eeprom_seq_pkg::OP_WRITE, 16'h0006));
    check("write_timeout", 32'h1, {31'h0, rd[17]});
    check("mem_006", 32'hFF, {24'h0, u_model.mem[16'h0006]});
    mute <= 1'b0;
    apb(1'b1, CTRL, 32'h0002_0000);
    apb(1'b0, CTRL, 32'h0);
    check("timeout_clear2", 32'h0, {31'h0, rd[17]});
    run(op(3'h1, 16'h0000));
    check("bad_code", 32'h1, {31'h0, rd[17]});
    $display("test timeout done");
    give_verdict();
  end

  // whole sequence needs well under 10000 cycles
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule

`default_nettype wire
